/* design/vcfc_pkg.sv */
// constants, types and register map of the serial port with flow control
package vcfc_pkg;
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned BAUD_DEFAULT = 115_200;
    localparam int unsigned BAUD_MIN     = 9_600;
    localparam int unsigned BAUD_MAX     = 921_600;
    // clock cycles per serial bit
    localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [15:0] DIV_MIN     = 16'(CLK_HZ / BAUD_MAX);
    localparam logic [15:0] DIV_MAX     = 16'(CLK_HZ / BAUD_MIN);
    localparam logic [2:0]  LAST_BIT    = 3'h7;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_DIV  = 5'h04;
    localparam logic [4:0] OFS_STAT = 5'h08;
    localparam logic [4:0] OFS_TXD  = 5'h0C;
    localparam logic [4:0] OFS_RXD  = 5'h10;

    localparam int unsigned RXB_DEPTH = 4;
    localparam logic [2:0]  RXB_FULL  = 3'h4;

    typedef enum logic [1:0] {
        VCFC_HS_OFF      = 2'b00,
        VCFC_HS_INBOUND  = 2'b01,
        VCFC_HS_OUTBOUND = 2'b10,
        VCFC_HS_BOTH     = 2'b11
    } vcfc_hs_mode_t;

    typedef enum logic [1:0] {
        VCFC_SER_IDLE  = 2'b00,
        VCFC_SER_START = 2'b01,
        VCFC_SER_DATA  = 2'b10,
        VCFC_SER_STOP  = 2'b11
    } vcfc_ser_state_t;

    typedef struct packed {
        logic rx_ovf;
        logic tx_drop;
        logic frame_err;
        logic link_en;
        logic peer_ready;
        logic rx_full;
        logic tx_busy;
        logic rx_avail;
    } vcfc_status_t;
endpackage

/* design/vcfc_uart_tx.sv */
// serial transmitter, 8 data bits, no parity, 1 stop bit
module vcfc_uart_tx (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [15:0] divisor,
    input  wire logic        start,
    input  wire logic [7:0]  data,
    output logic             txd,
    output logic             busy
);
    vcfc_pkg::vcfc_ser_state_t state_r;
    logic [15:0]               cnt_r;
    logic [2:0]                bit_r;
    logic [7:0]                shf_r;
    wire                       tick = cnt_r >= (divisor - 16'h0001);

    assign busy = state_r != vcfc_pkg::VCFC_SER_IDLE;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= vcfc_pkg::VCFC_SER_IDLE;
            cnt_r   <= 16'h0000;
            bit_r   <= 3'h0;
            shf_r   <= 8'h00;
            txd     <= 1'b1;
        end else begin
            cnt_r <= (!busy || tick) ? 16'h0000 : cnt_r + 16'h0001;
            case (state_r)
                vcfc_pkg::VCFC_SER_IDLE: if (start) begin
                    shf_r   <= data;
                    txd     <= 1'b0;
                    state_r <= vcfc_pkg::VCFC_SER_START;
                end
                vcfc_pkg::VCFC_SER_START: if (tick) begin
                    txd     <= shf_r[0];
                    shf_r   <= {1'b0, shf_r[7:1]};
                    bit_r   <= 3'h0;
                    state_r <= vcfc_pkg::VCFC_SER_DATA;
                end
                vcfc_pkg::VCFC_SER_DATA: if (tick) begin
                    if (bit_r == vcfc_pkg::LAST_BIT) begin
                        txd     <= 1'b1;
                        state_r <= vcfc_pkg::VCFC_SER_STOP;
                    end else begin
                        txd   <= shf_r[0];
                        shf_r <= {1'b0, shf_r[7:1]};
                        bit_r <= bit_r + 3'h1;
                    end
                end
                vcfc_pkg::VCFC_SER_STOP: if (tick) begin
                    state_r <= vcfc_pkg::VCFC_SER_IDLE;
                end
                default: state_r <= vcfc_pkg::VCFC_SER_IDLE;
            endcase
        end
    end
endmodule

/* design/vcfc_uart_rx.sv */
// serial receiver, 8 data bits, no parity, 1 stop bit, mid-bit sampling
module vcfc_uart_rx (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [15:0] divisor,
    input  wire logic        rxd,
    output logic             done,
    output logic             frame_err,
    output logic [7:0]       data
);
    vcfc_pkg::vcfc_ser_state_t state_r;
    logic [15:0]               cnt_r;
    logic [2:0]                bit_r;
    logic [7:0]                shf_r;
    wire                       tick = cnt_r >= (divisor - 16'h0001);
    wire                       half = cnt_r >= {1'b0, divisor[15:1]};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r   <= vcfc_pkg::VCFC_SER_IDLE;
            cnt_r     <= 16'h0000;
            bit_r     <= 3'h0;
            shf_r     <= 8'h00;
            done      <= 1'b0;
            frame_err <= 1'b0;
            data      <= 8'h00;
        end else begin
            done      <= 1'b0;
            frame_err <= 1'b0;
            cnt_r     <= cnt_r + 16'h0001;
            case (state_r)
                vcfc_pkg::VCFC_SER_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (!rxd) state_r <= vcfc_pkg::VCFC_SER_START;
                end
                vcfc_pkg::VCFC_SER_START: if (half) begin
                    cnt_r   <= 16'h0000;
                    bit_r   <= 3'h0;
                    // a start bit gone high by mid-bit was a glitch
                    state_r <= rxd ? vcfc_pkg::VCFC_SER_IDLE : vcfc_pkg::VCFC_SER_DATA;
                end
                vcfc_pkg::VCFC_SER_DATA: if (tick) begin
                    cnt_r <= 16'h0000;
                    shf_r <= {rxd, shf_r[7:1]};
                    bit_r <= bit_r + 3'h1;
                    if (bit_r == vcfc_pkg::LAST_BIT) state_r <= vcfc_pkg::VCFC_SER_STOP;
                end
                vcfc_pkg::VCFC_SER_STOP: if (tick) begin
                    done      <= 1'b1;
                    frame_err <= !rxd;
                    data      <= shf_r;
                    state_r   <= vcfc_pkg::VCFC_SER_IDLE;
                end
                default: state_r <= vcfc_pkg::VCFC_SER_IDLE;
            endcase
        end
    end
endmodule

/* design/vcfc_top.sv */
// serial port towards the target with selectable hardware handshake
module vcfc_top (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             serial_to_target,
    input  wire logic        serial_from_target,
    output logic             target_clear_to_send_n_o,
    output logic             target_clear_to_send_n_oe_n,
    input  wire logic        target_request_to_send_n,
    input  wire logic        link_pass_enable
);
    // byte lane merge for partial writes
    function automatic logic [7:0] lane(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic       en);
        lane = en ? new_v : old_v;
    endfunction

    // ---------------- pin synchronisers ----------------
    // order: {link enable, request-to-send, serial in}
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    wire        rxd_s     = sync2_r[0];
    wire        rts_n_s   = sync2_r[1];
    wire        link_s    = sync2_r[2];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= 3'b011;
            sync2_r <= 3'b011;
        end else begin
            sync1_r <= {link_pass_enable, target_request_to_send_n, serial_from_target};
            sync2_r <= sync1_r;
        end
    end

    // ---------------- configuration ----------------
    vcfc_pkg::vcfc_hs_mode_t mode_r;
    logic [15:0]             div_r;

    wire inbound_on  = (mode_r == vcfc_pkg::VCFC_HS_INBOUND) ||
                       (mode_r == vcfc_pkg::VCFC_HS_BOTH);
    wire outbound_on = (mode_r == vcfc_pkg::VCFC_HS_OUTBOUND) ||
                       (mode_r == vcfc_pkg::VCFC_HS_BOTH);
    wire peer_ready  = !rts_n_s;

    // ---------------- bus slave ----------------
    // one wait state on every access; the effect lands when waitrequest is low
    logic done_r;
    wire  req    = avs_read || avs_write;
    wire  access = req && done_r;
    wire  wr     = access && avs_write;
    wire  rd     = access && avs_read;

    wire  sel_ctrl = avs_address == vcfc_pkg::OFS_CTRL;
    wire  sel_div  = avs_address == vcfc_pkg::OFS_DIV;
    wire  sel_stat = avs_address == vcfc_pkg::OFS_STAT;
    wire  sel_txd  = avs_address == vcfc_pkg::OFS_TXD;
    wire  sel_rxd  = avs_address == vcfc_pkg::OFS_RXD;

    assign avs_waitrequest = req && !done_r;

    always_ff @(posedge ref_clk) begin
        if (srst) done_r <= 1'b0;
        else      done_r <= req && !done_r;
    end

    // divisor write, clamped into the supported range
    wire [15:0] div_wr = {lane(div_r[15:8], avs_writedata[15:8], avs_byteenable[1]),
                          lane(div_r[7:0], avs_writedata[7:0], avs_byteenable[0])};
    wire [15:0] div_clamped = (div_wr < vcfc_pkg::DIV_MIN) ? vcfc_pkg::DIV_MIN :
                              (div_wr > vcfc_pkg::DIV_MAX) ? vcfc_pkg::DIV_MAX : div_wr;
    wire [7:0]  ctrl_wr = lane({6'h00, mode_r}, avs_writedata[7:0], avs_byteenable[0]);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_r <= vcfc_pkg::VCFC_HS_OFF;
            div_r  <= vcfc_pkg::DIV_DEFAULT;
        end else begin
            if (wr && sel_ctrl) mode_r <= vcfc_pkg::vcfc_hs_mode_t'(ctrl_wr[1:0]);
            if (wr && sel_div)  div_r  <= div_clamped;
        end
    end

    // ---------------- transmit path ----------------
    logic       hold_v_r;
    logic [7:0] hold_d_r;
    logic       tx_busy;
    logic       tx_drop_r;

    // link enable and, with outbound control, the peer's ready level gate
    // only the launch of a new character; a running one is never cut
    wire tx_permit = link_s && (!outbound_on || peer_ready);
    wire tx_start  = hold_v_r && !tx_busy && tx_permit;
    wire hold_free = !hold_v_r || tx_start;
    wire txd_wr    = wr && sel_txd && avs_byteenable[0];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold_v_r <= 1'b0;
            hold_d_r <= 8'h00;
        end else if (txd_wr && hold_free) begin
            hold_v_r <= 1'b1;
            hold_d_r <= avs_writedata[7:0];
        end else if (tx_start) begin
            hold_v_r <= 1'b0;
        end
    end

    vcfc_uart_tx u_tx (
        .ref_clk (ref_clk),
        .srst    (srst),
        .divisor (div_r),
        .start   (tx_start),
        .data    (hold_d_r),
        .txd     (serial_to_target),
        .busy    (tx_busy)
    );

    // ---------------- receive path ----------------
    logic       rx_done;
    logic       rx_ferr;
    logic [7:0] rx_data;

    vcfc_uart_rx u_rx (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .divisor   (div_r),
        .rxd       (rxd_s),
        .done      (rx_done),
        .frame_err (rx_ferr),
        .data      (rx_data)
    );

    // receive buffer
    logic [7:0] rxb_mem [vcfc_pkg::RXB_DEPTH];
    logic [1:0] rxb_wp_r;
    logic [1:0] rxb_rp_r;
    logic [2:0] rxb_cnt_r;
    logic       cts_n_r;

    wire rxb_full  = rxb_cnt_r == vcfc_pkg::RXB_FULL;
    wire rxb_empty = rxb_cnt_r == 3'h0;
    wire rx_in     = rx_done && link_s;
    wire rxb_push  = rx_in && !rxb_full;
    wire rxb_pop   = rd && sel_rxd && !rxb_empty;
    wire rx_ovf_ev = rx_in && rxb_full;

    wire [2:0] rxb_cnt_nxt = rxb_cnt_r + {2'b00, rxb_push} - {2'b00, rxb_pop};

    always_ff @(posedge ref_clk) begin
        if (rxb_push) rxb_mem[rxb_wp_r] <= rx_data;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxb_wp_r  <= 2'h0;
            rxb_rp_r  <= 2'h0;
            rxb_cnt_r <= 3'h0;
            cts_n_r   <= 1'b0;
        end else begin
            if (rxb_push) rxb_wp_r <= rxb_wp_r + 2'h1;
            if (rxb_pop)  rxb_rp_r <= rxb_rp_r + 2'h1;
            rxb_cnt_r <= rxb_cnt_nxt;
            // high means not ready: raised exactly while the buffer is full
            cts_n_r   <= rxb_cnt_nxt == vcfc_pkg::RXB_FULL;
        end
    end

    // clear-to-send pin: driven only in the inbound-controlled modes
    assign target_clear_to_send_n_o    = cts_n_r;
    assign target_clear_to_send_n_oe_n = !inbound_on;

    // ---------------- sticky status flags ----------------
    logic frame_err_r;
    logic rx_ovf_r;

    wire stat_clr = wr && sel_stat && avs_byteenable[0];
    wire clr_ferr = stat_clr && avs_writedata[5];
    wire clr_drop = stat_clr && avs_writedata[6];
    wire clr_ovf  = stat_clr && avs_writedata[7];
    wire drop_ev  = txd_wr && !hold_free;

    // an event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_err_r <= 1'b0;
            tx_drop_r   <= 1'b0;
            rx_ovf_r    <= 1'b0;
        end else begin
            frame_err_r <= (frame_err_r && !clr_ferr) || (rx_in && rx_ferr);
            tx_drop_r   <= (tx_drop_r && !clr_drop) || drop_ev;
            rx_ovf_r    <= (rx_ovf_r && !clr_ovf) || rx_ovf_ev;
        end
    end

    vcfc_pkg::vcfc_status_t status;
    assign status = '{
        rx_ovf:     rx_ovf_r,
        tx_drop:    tx_drop_r,
        frame_err:  frame_err_r,
        link_en:    link_s,
        peer_ready: peer_ready,
        rx_full:    rxb_full,
        tx_busy:    tx_busy || hold_v_r,
        rx_avail:   !rxb_empty
    };

    // ---------------- read data ----------------
    wire [31:0] rd_mux = sel_ctrl ? {30'h0, mode_r} :
                         sel_div  ? {16'h0000, div_r} :
                         sel_stat ? {24'h000000, status} :
                         sel_rxd  ? {24'h000000, rxb_empty ? 8'h00 : rxb_mem[rxb_rp_r]} :
                         32'h00000000;

    // captured in the wait cycle, stands through the answer cycle
    always_ff @(posedge ref_clk) begin
        if (srst)                  avs_readdata <= 32'h00000000;
        else if (avs_read && !done_r) avs_readdata <= rd_mux;
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_reset_config: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        srst |=> (mode_r == vcfc_pkg::VCFC_HS_OFF) && (div_r == vcfc_pkg::DIV_DEFAULT))
        else $error("configuration after reset is not the default");

    a_divisor_range: assert property (
        (div_r >= vcfc_pkg::DIV_MIN) && (div_r <= vcfc_pkg::DIV_MAX))
        else $error("bit divisor outside the supported range");

    a_cts_on_full: assert property (
        rxb_push && !rxb_pop && (rxb_cnt_r == vcfc_pkg::RXB_FULL - 3'h1)
        |=> target_clear_to_send_n_o)
        else $error("clear-to-send not raised when the buffer fills");

    a_cts_driven: assert property (
        inbound_on |-> !target_clear_to_send_n_oe_n &&
                       (target_clear_to_send_n_o == rxb_full))
        else $error("clear-to-send not driven in an inbound mode");

    a_cts_released: assert property (
        !inbound_on |-> target_clear_to_send_n_oe_n)
        else $error("clear-to-send driven while inbound control is off");

    a_tx_gated: assert property (
        (outbound_on && rts_n_s) || !link_s |-> !tx_start)
        else $error("character launched while the target is not ready");

    sequence s_launch;
        tx_start;
    endsequence
    sequence s_running;
        tx_busy [*8];
    endsequence
    a_char_kept: assert property (
        s_launch |=> s_running)
        else $error("character cut short after launch");

    a_free_send: assert property (
        !outbound_on && link_s && hold_v_r && !tx_busy |=> !serial_to_target)
        else $error("request-to-send not ignored without outbound control");

    a_rx_ovf_flag: assert property (
        rx_in && rxb_full && !rxb_pop |=> rx_ovf_r && (rxb_cnt_r == vcfc_pkg::RXB_FULL))
        else $error("character on full buffer not flagged as overrun");
endmodule

/* bench/vcfc_target_model.sv */
// behavioural target-side serial port with a clear-to-send hold-off; it has no request-to-send line
module vcfc_target_model #(
    parameter int BIT_CYC = 135
) (
    input  wire logic ref_clk,
    input  wire logic rx_line,
    input  wire logic cts_n,
    input  wire logic hs_en,
    output logic      tx_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q[$];

    initial tx_line = 1'b1;

    // one 8N1 character, held off while clear-to-send is high
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(posedge ref_clk);
        for (int w = 0; w < 20000 && hs_en && cts_n !== 1'b0; w++) begin
            @(posedge ref_clk);
        end
        for (int i = 0; i < 10; i++) begin
            tx_line <= fr[i];
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask

    // always ready for one more character; the model drives no request line of its own
    always begin : rx_proc
        logic [7:0] b;
        @(negedge rx_line);
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge ref_clk);
            b[i] = rx_line;
        end
        repeat (BIT_CYC) @(posedge ref_clk);
        if (rx_line === 1'b1) begin
            got_q.push_back(b);
        end
    end
endmodule

/* bench/test_vcom_uart_flow_control.sv */
// self-checking bench for the serial port with selectable handshake
module test_vcom_uart_flow_control;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BIT_CYC = 135;

    logic        ref_clk = 1'b0;
    logic        srst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        serial_to_target;
    logic        serial_from_target;
    logic        cts_n_o;
    logic        cts_oe_n;
    logic        rts_n;
    logic        link_en;
    logic        hs_en;
    logic        cts_line;
    int          failures;
    int          samples_checked;

    // undriven clear-to-send rests at the ready level
    assign cts_line = cts_oe_n ? 1'b0 : cts_n_o;

    always #4 ref_clk = ~ref_clk;

    vcfc_top i_vcfc_top (
        .ref_clk                     (ref_clk),
        .srst                        (srst),
        .avs_address                 (avs_address),
        .avs_read                    (avs_read),
        .avs_write                   (avs_write),
        .avs_writedata               (avs_writedata),
        .avs_byteenable              (avs_byteenable),
        .avs_readdata                (avs_readdata),
        .avs_waitrequest             (avs_waitrequest),
        .serial_to_target            (serial_to_target),
        .serial_from_target          (serial_from_target),
        .target_clear_to_send_n_o    (cts_n_o),
        .target_clear_to_send_n_oe_n (cts_oe_n),
        .target_request_to_send_n    (rts_n),
        .link_pass_enable            (link_en)
    );

    vcfc_target_model #(.BIT_CYC(BIT_CYC)) i_vcfc_target_model (
        .ref_clk (ref_clk),
        .rx_line (serial_to_target),
        .cts_n   (cts_line),
        .hs_en   (hs_en),
        .tx_line (serial_from_target)
    );

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        // waitrequest read at each rising edge, before the slave updates
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            wrap_up();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // let the answer edge settle before callers look at outputs
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask

    function automatic int got();
        return i_vcfc_target_model.got_q.size();
    endfunction

    task automatic wait_q(input int n);
        for (int c = 0; c < 20 * BIT_CYC && got() < n; c++) @(posedge ref_clk);
    endtask

    task automatic arrive_chk(input string what, input int n0, input logic [7:0] b);
        wait_q(n0 + 1);
        check(what, 32'(got() - n0), 32'h1);
        check(what, {24'h0, i_vcfc_target_model.got_q[n0]}, {24'h0, b});
    endtask

    task automatic tx_chk(input string what, input logic [7:0] b, input bit arrive);
        int n0;
        n0 = got();
        wr(vcfc_pkg::OFS_TXD, {24'h0, b});
        if (arrive) begin
            arrive_chk(what, n0, b);
        end else begin
            wait_q(n0 + 1);
            check(what, 32'(got() - n0), 32'h0);
        end
    endtask

    task automatic pop_chk(input string what, input logic [7:0] exp);
        logic [31:0] q;
        q = 32'h0;
        for (int n = 0; n < 4000 && q[0] !== 1'b1; n++) bus(1'b0, vcfc_pkg::OFS_STAT, 32'h0, q);
        bus(1'b0, vcfc_pkg::OFS_RXD, 32'h0, q);
        check(what, q, {24'h0, exp});
    endtask

    task automatic set_pin(input bit on_link, input logic v);
        @(posedge ref_clk);
        if (on_link) begin
            link_en <= v;
        end else begin
            rts_n <= v;
        end
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic sc_reset();
        rd_chk("ctrl reset", vcfc_pkg::OFS_CTRL, 32'h0);
        rd_chk("div reset", vcfc_pkg::OFS_DIV, 32'h0000_043D);
        rd_chk("stat reset", vcfc_pkg::OFS_STAT, 32'h0000_0018);
        wr(5'h14, 32'hFFFF_FFFF);
        rd_chk("unmapped", 5'h14, 32'h0);
        check("cts undriven", {31'h0, cts_oe_n}, 32'h1);
    endtask

    task automatic sc_rate();
        wr(vcfc_pkg::OFS_DIV, 32'h0);
        rd_chk("div low clamp", vcfc_pkg::OFS_DIV, 32'h0000_0087);
        wr(vcfc_pkg::OFS_DIV, 32'h0000_FFFF);
        rd_chk("div high clamp", vcfc_pkg::OFS_DIV, 32'h0000_32DC);
        wr(vcfc_pkg::OFS_DIV, 32'h0000_0400);
        rd_chk("div in range", vcfc_pkg::OFS_DIV, 32'h0000_0400);
        wr(vcfc_pkg::OFS_DIV, 32'h0000_0087);
    endtask

    task automatic sc_off_and_link();
        int n0;
        set_pin(1'b0, 1'b1);
        tx_chk("off ignores rts", 8'hA5, 1'b1);
        set_pin(1'b0, 1'b0);
        set_pin(1'b1, 1'b0);
        n0 = got();
        tx_chk("link closed", 8'h77, 1'b0);
        set_pin(1'b1, 1'b1);
        arrive_chk("link reopened", n0, 8'h77);
    endtask

    task automatic sc_outbound();
        int n0;
        wr(vcfc_pkg::OFS_CTRL, 32'h2);
        check("cts undriven out", {31'h0, cts_oe_n}, 32'h1);
        n0 = got();
        wr(vcfc_pkg::OFS_TXD, 32'h3C);
        for (int c = 0; c < 1000 && serial_to_target !== 1'b0; c++) @(posedge ref_clk);
        rts_n <= 1'b1;
        arrive_chk("started finishes", n0, 8'h3C);
        tx_chk("held by rts", 8'hC3, 1'b0);
        wr(vcfc_pkg::OFS_TXD, 32'hEE);
        rd_chk("drop flagged", vcfc_pkg::OFS_STAT, 32'h0000_0052);
        wr(vcfc_pkg::OFS_STAT, 32'h40);
        set_pin(1'b0, 1'b0);
        arrive_chk("released by rts", n0 + 1, 8'hC3);
    endtask

    task automatic sc_inbound();
        wr(vcfc_pkg::OFS_CTRL, 32'h1);
        check("cts driven in", {31'h0, cts_oe_n}, 32'h0);
        // the fifth character ignores clear-to-send and overruns the buffer
        for (int i = 0; i < 5; i++) i_vcfc_target_model.send(8'(8'h11 * (i + 1)));
        repeat (4) @(negedge ref_clk);
        check("cts on full", {31'h0, cts_n_o}, 32'h1);
        rd_chk("overrun flagged", vcfc_pkg::OFS_STAT, 32'h0000_009D);
        wr(vcfc_pkg::OFS_STAT, 32'h80);
        rd_chk("overrun cleared", vcfc_pkg::OFS_STAT, 32'h0000_001D);
        rd_chk("rx first", vcfc_pkg::OFS_RXD, 32'h11);
        repeat (2) @(negedge ref_clk);
        check("cts after pop", {31'h0, cts_n_o}, 32'h0);
        for (int i = 1; i < 4; i++) pop_chk("rx order", 8'(8'h11 * (i + 1)));
        set_pin(1'b0, 1'b1);
        tx_chk("in ignores rts", 8'h5A, 1'b1);
        set_pin(1'b0, 1'b0);
    endtask

    task automatic sc_both();
        int n0;
        wr(vcfc_pkg::OFS_CTRL, 32'h3);
        check("cts driven both", {31'h0, cts_oe_n}, 32'h0);
        hs_en = 1'b1;
        fork
            begin
                for (int i = 0; i < 6; i++) i_vcfc_target_model.send(8'(8'h60 + i));
            end
        join_none
        for (int c = 0; c < 8000 && cts_n_o !== 1'b1; c++) @(negedge ref_clk);
        repeat (3000) @(posedge ref_clk);
        rd_chk("full no overrun", vcfc_pkg::OFS_STAT, 32'h0000_001D);
        for (int i = 0; i < 6; i++) pop_chk("rx stalled order", 8'(8'h60 + i));
        hs_en = 1'b0;
        set_pin(1'b0, 1'b1);
        n0 = got();
        tx_chk("both gated", 8'h99, 1'b0);
        set_pin(1'b0, 1'b0);
        arrive_chk("both released", n0, 8'h99);
    endtask

    initial begin
        failures        = 0;
        samples_checked = 0;
        srst            = 1'b1;
        avs_address     = 5'h00;
        avs_read        = 1'b0;
        avs_write       = 1'b0;
        avs_writedata   = 32'h0;
        avs_byteenable  = 4'hF;
        rts_n           = 1'b0;
        link_en         = 1'b1;
        hs_en           = 1'b0;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sc_reset();
        sc_rate();
        sc_off_and_link();
        sc_outbound();
        sc_inbound();
        sc_both();
        wrap_up();
    end
endmodule
